// >>> rtl/apdu_defs.svh
/*
 * Constants of the automatic power-down unit: register selects, bit
 * positions, reset values and the idle count.
 * Assumes it is included by bare name from the unit's design files.
 */
`ifndef APDU_DEFS_SVH
`define APDU_DEFS_SVH

// Register selects on the write/read port
`define APDU_SEL_POWER_MODE  1'h0
`define APDU_SEL_PLD_GATING  1'h1

// Power-up value of both power-management registers
`define APDU_REG_RESET       8'h00

// Fields of power_mode_control
`define APDU_PMC_AUTO_PD     1
`define APDU_PMC_LOW_POWER   3
`define APDU_PMC_CLK_OFF     4

// Fields of pld_input_gating
`define APDU_GATE_ADDR       0
`define APDU_GATE_CTRL_LO    2
`define APDU_GATE_STROBE     5
`define APDU_GATE_HIGH_WR    6

// Idle periods of the PLD clock before power-down
`define APDU_IDLE_LIMIT      4'hf
`define APDU_CNT_ZERO        4'h0
`define APDU_CNT_ONE         4'h1

`endif

// >>> rtl/apdu_pkg.sv
/*
 * Types shared by the automatic power-down unit.
 * Assumes nothing of its surroundings.
 */
package apdu_pkg;

   // One power-management register
   typedef logic [7:0] apdu_byte_t;

   // Idle counter value
   typedef logic [3:0] apdu_count_t;

   // Power state of the device
   typedef enum logic [0:0] {
      APDU_RUN,
      APDU_DOWN
   } apdu_pwr_e;

endpackage

// >>> rtl/apdu_idle_counter.sv
/*
 * Four-bit idle counter, advanced by rising edges of the PLD clock
 * input while the address strobe rests at the power-down level.
 * Assumes the PLD clock input is sampled on i_clk, which runs faster.
 */
`timescale 1ns/1ps
`include "apdu_defs.svh"

module apdu_idle_counter
(
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_b,
   input  wire logic                 i_clear,
   input  wire logic                 i_count_ok,
   input  wire logic                 i_pld_clock_input,
   output      apdu_pkg::apdu_count_t o_count
);
   import apdu_pkg::*;

   logic        clk_prev;   // Last sample of the PLD clock input
   logic        clk_rise;   // Rising edge of the PLD clock input
   apdu_count_t count;      // Idle periods seen so far

   // Remember the clock input; never gated by the PLD clock enable
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         clk_prev <= 1'b0;
      else
         clk_prev <= i_pld_clock_input;
   end

   assign clk_rise = i_pld_clock_input & ~clk_prev;

   // Count idle periods, saturating at the limit
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         count <= `APDU_CNT_ZERO;
      else if (i_clear)
         count <= `APDU_CNT_ZERO;
      else if (clk_rise && i_count_ok && count != `APDU_IDLE_LIMIT)
         count <= count + `APDU_CNT_ONE;
   end

   assign o_count = count;

endmodule

// >>> rtl/apdu_pm_regs.sv
/*
 * The two power-management registers, written over the device's own
 * register port. Cleared by power-up reset only.
 * Assumes the warm reset pin never reaches i_rst_b.
 */
`timescale 1ns/1ps
`include "apdu_defs.svh"

module apdu_pm_regs
(
   input  wire logic                i_clk,
   input  wire logic                i_rst_b,
   input  wire logic                i_wr,
   input  wire logic                i_sel,
   input  wire apdu_pkg::apdu_byte_t i_wdata,
   output      apdu_pkg::apdu_byte_t o_power_mode_control,
   output      apdu_pkg::apdu_byte_t o_pld_input_gating
);
   import apdu_pkg::*;

   apdu_byte_t power_mode_control;  // Enable, PLD power, clock gate
   apdu_byte_t pld_input_gating;    // PLD input disconnect bits

   // Power mode register; warm reset leaves it alone
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         power_mode_control <= `APDU_REG_RESET;
      else if (i_wr && i_sel == `APDU_SEL_POWER_MODE)
         power_mode_control <= i_wdata;
   end

   // Input gating register; warm reset leaves it alone
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         pld_input_gating <= `APDU_REG_RESET;
      else if (i_wr && i_sel == `APDU_SEL_PLD_GATING)
         pld_input_gating <= i_wdata;
   end

   assign o_power_mode_control = power_mode_control;
   assign o_pld_input_gating   = pld_input_gating;

endmodule

// >>> rtl/apdu_top.sv
/*
 * Automatic power-down unit: watches the address strobe, counts idle
 * PLD clock periods, enters power-down, blocks bus inputs from the
 * memories and the low address byte from the PLDs, and gates single
 * inputs of the PLD AND array.
 * Assumes all pins are synchronous to i_clk, that i_rst_b is the
 * power-up reset, and that the warm reset pin arrives on its own input.
 */
// How it works
// - Idle strobe with feature on enters power-down
// - Four-bit counter, fifteen PLD clocks, then power-down
// - Power-down blocks bus inputs, deselects all memories
// - Strobe pulsing again leaves power-down at once
// - Chip select low or reset high also wakes
// - Enable bit alone arms power-down entry
// - PLD logic unaffected; only power bit matters
// - Hold gpio/PLD pins, three-state data and peripheral
// - Clock gating never stops the idle counter
// - Chip select high only idles memories
// - Mode bit 1 enables automatic power-down
// - Mode bit 3 selects low-power PLD operation
// - Mode bit 4 disconnects PLD clock input
// - Registers clear at power-up, keep on warm reset
// - Gating bit 0 disconnects low address byte
// - Gating bits 2..4 disconnect control inputs
// - Gating bit 5 disconnects address strobe
// - Gating bit 6 disconnects high write input
// - Count only when strobe rests at polarity level
// - PLD clock pin drives PLD and counter
`timescale 1ns/1ps
`include "apdu_defs.svh"

module apdu_top
(
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_b,
   // Register port of the device
   input  wire logic                 i_reg_wr,
   input  wire logic                 i_reg_sel,
   input  wire apdu_pkg::apdu_byte_t i_reg_wdata,
   output      apdu_pkg::apdu_byte_t o_reg_rdata,
   // Microcontroller bus side
   input  wire logic                 i_address_strobe,
   input  wire logic                 i_strobe_pd_polarity,
   input  wire logic [7:0]           i_mcu_addr_lo,
   input  wire logic [15:0]          i_mcu_data,
   input  wire logic [2:0]           i_mcu_control_inputs,
   input  wire logic                 i_high_write_or_byte_enable,
   input  wire logic                 i_pld_clock_input,
   input  wire logic                 i_chip_select_b,
   input  wire logic                 i_warm_reset_b,
   // Pin drive requests from the port logic
   input  wire logic [7:0]           i_gpio_out,
   input  wire logic [7:0]           i_pld_out,
   input  wire logic [15:0]          i_data_port_out,
   input  wire logic                 i_data_port_oe,
   input  wire logic [7:0]           i_periph_out,
   input  wire logic                 i_periph_oe,
   // Memory side
   output      logic [7:0]           o_mem_addr_lo,
   output      logic [15:0]          o_mem_data,
   output      logic                 o_mem_select,
   // PLD AND array inputs and PLD power mode
   output      logic [7:0]           o_pld_addr_lo,
   output      logic [2:0]           o_pld_control_inputs,
   output      logic                 o_pld_address_strobe,
   output      logic                 o_pld_high_write,
   output      logic                 o_pld_clock,
   output      logic                 o_pld_low_power,
   // Pins
   output      logic [7:0]           o_gpio_out,
   output      logic [7:0]           o_pld_pin_out,
   output      logic [15:0]          o_data_port_out,
   output      logic                 o_data_port_oe,
   output      logic [7:0]           o_periph_out,
   output      logic                 o_periph_oe,
   output      logic [7:0]           o_latched_addr_out,
   // Status
   output      logic                 o_power_down_signal,
   output      apdu_pkg::apdu_count_t o_idle_count
);
   import apdu_pkg::*;

   apdu_byte_t  power_mode_control;  // Mode register contents
   apdu_byte_t  pld_input_gating;    // Gating register contents
   apdu_count_t count;               // Idle counter value
   apdu_pwr_e   pwr_state;           // Current power state
   apdu_pwr_e   next_pwr_state;      // Power state for the next cycle

   logic strobe_prev;   // Previous strobe level
   logic cs_prev_b;     // Previous chip select level
   logic rst_prev_b;    // Previous warm reset level
   logic strobe_pulse;  // Strobe changed this cycle
   logic cs_return;     // Chip select went low
   logic rst_return;    // Warm reset went high
   logic wake;          // Any wake-up event
   logic auto_pd;       // Automatic power-down enabled
   logic count_ok;      // Strobe rests at the idle level
   logic blocked;       // Bus inputs blocked
   logic addr_off;      // Low address byte off the PLD array
   logic strobe_off;    // Strobe off the PLD array
   logic high_wr_off;   // High write input off the PLD array
   logic clk_off;       // Clock input off the PLD array
   logic [2:0] ctrl_off; // Control inputs off the PLD array

   // Register pair, written by software at run time
   apdu_pm_regs u_regs
   (
      .i_clk                (i_clk),
      .i_rst_b              (i_rst_b),
      .i_wr                 (i_reg_wr),
      .i_sel                (i_reg_sel),
      .i_wdata              (i_reg_wdata),
      .o_power_mode_control (power_mode_control),
      .o_pld_input_gating   (pld_input_gating)
   );

   // Field decode
   assign auto_pd     = power_mode_control[`APDU_PMC_AUTO_PD];
   assign clk_off     = power_mode_control[`APDU_PMC_CLK_OFF];
   assign addr_off    = pld_input_gating[`APDU_GATE_ADDR];
   assign strobe_off  = pld_input_gating[`APDU_GATE_STROBE];
   assign high_wr_off = pld_input_gating[`APDU_GATE_HIGH_WR];

   // One disconnect bit per control input
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_ctrl
         assign ctrl_off[gi] = pld_input_gating[`APDU_GATE_CTRL_LO + gi];
      end
   endgenerate

   // Previous levels of the wake-up sources
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         strobe_prev <= 1'b0;
         cs_prev_b   <= 1'b1;
         rst_prev_b  <= 1'b1;
      end
      else
      begin
         strobe_prev <= i_address_strobe;
         cs_prev_b   <= i_chip_select_b;
         rst_prev_b  <= i_warm_reset_b;
      end
   end

   // Wake-up events
   assign strobe_pulse = i_address_strobe ^ strobe_prev;
   assign cs_return    = cs_prev_b & ~i_chip_select_b;
   assign rst_return   = ~rst_prev_b & i_warm_reset_b;
   assign wake         = strobe_pulse | cs_return | rst_return;

   // Counting needs the enable and a resting strobe at the idle level
   assign count_ok = auto_pd && !strobe_pulse &&
                     (i_address_strobe == i_strobe_pd_polarity);

   // Idle counter on the raw PLD clock input
   apdu_idle_counter u_cnt
   (
      .i_clk             (i_clk),
      .i_rst_b           (i_rst_b),
      .i_clear           (wake | ~auto_pd),
      .i_count_ok        (count_ok),
      .i_pld_clock_input (i_pld_clock_input),
      .o_count           (count)
   );

   // Next power state
   always_comb
   begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         APDU_RUN:
         begin
            // Enter when fifteen idle periods are done
            if (auto_pd && !wake && count == `APDU_IDLE_LIMIT)
               next_pwr_state = APDU_DOWN;
         end
         APDU_DOWN:
         begin
            // Leave on any wake-up source or when disabled
            if (wake || !auto_pd)
               next_pwr_state = APDU_RUN;
         end
         default:
            next_pwr_state = APDU_RUN;
      endcase
   end

   // Power state register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         pwr_state <= APDU_RUN;
      else
         pwr_state <= next_pwr_state;
   end

   assign blocked = (next_pwr_state == APDU_DOWN);

   // Power-down flag and counter status
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_power_down_signal <= 1'b0;
         o_idle_count        <= `APDU_CNT_ZERO;
      end
      else
      begin
         o_power_down_signal <= blocked;
         o_idle_count        <= count;
      end
   end

   // Memory side: frozen and deselected while blocked
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_mem_addr_lo <= 8'h00;
         o_mem_data    <= 16'h0000;
         o_mem_select  <= 1'b0;
      end
      else
      begin
         if (!blocked)
         begin
            // Bus passes through in normal operation
            o_mem_addr_lo <= i_mcu_addr_lo;
            o_mem_data    <= i_mcu_data;
         end
         // Chip select high idles memories only
         o_mem_select <= !blocked && !i_chip_select_b;
      end
   end

   // PLD AND array inputs, each with its own disconnect
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_pld_addr_lo        <= 8'h00;
         o_pld_control_inputs <= 3'h0;
         o_pld_address_strobe <= 1'b0;
         o_pld_high_write     <= 1'b0;
         o_pld_clock          <= 1'b0;
      end
      else
      begin
         // Address is blocked by power-down or its gate bit
         if (!blocked && !addr_off)
            o_pld_addr_lo <= i_mcu_addr_lo;
         else if (addr_off)
            o_pld_addr_lo <= 8'h00;
         o_pld_control_inputs <= i_mcu_control_inputs & ~ctrl_off;
         o_pld_address_strobe <= i_address_strobe & ~strobe_off;
         o_pld_high_write     <= i_high_write_or_byte_enable &
                                 ~high_wr_off;
         o_pld_clock          <= i_pld_clock_input & ~clk_off;
      end
   end

   // PLD power mode follows its bit alone, not power-down
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         o_pld_low_power <= 1'b0;
      else
         o_pld_low_power <= power_mode_control[`APDU_PMC_LOW_POWER];
   end

   // Pin levels: hold general pins, float data and peripheral
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_gpio_out         <= 8'h00;
         o_pld_pin_out      <= 8'h00;
         o_data_port_out    <= 16'h0000;
         o_data_port_oe     <= 1'b0;
         o_periph_out       <= 8'h00;
         o_periph_oe        <= 1'b0;
         o_latched_addr_out <= 8'h00;
      end
      else
      begin
         // PLD and I/O stay live
         o_gpio_out      <= i_gpio_out;
         o_pld_pin_out   <= i_pld_out;
         o_data_port_out <= i_data_port_out;
         o_periph_out    <= i_periph_out;
         // Three-state during power-down
         o_data_port_oe  <= i_data_port_oe && !blocked;
         o_periph_oe     <= i_periph_oe && !blocked;
         // Latched address is undefined while blocked; it is frozen
         if (!blocked)
            o_latched_addr_out <= i_mcu_addr_lo;
      end
   end

   // Read back the selected register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         o_reg_rdata <= `APDU_REG_RESET;
      else if (i_reg_sel == `APDU_SEL_POWER_MODE)
         o_reg_rdata <= power_mode_control;
      else
         o_reg_rdata <= pld_input_gating;
   end

endmodule

// >>> dv/apdu_assertions.sv
/*
 * Checker of the automatic power-down unit: wake-up, blocking and
 * idle counting seen at the ports of apdu_top.
 * Assumes one clock domain and the power-up reset on i_rst_b.
 */
`timescale 1ns/1ps
`include "apdu_defs.svh"

module apdu_assertions
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_address_strobe,
   input  wire logic                  i_chip_select_b,
   input  wire logic                  i_warm_reset_b,
   input  wire logic [7:0]            i_gpio_out,
   input  wire logic [7:0]            i_pld_out,
   input  wire logic [7:0]            o_mem_addr_lo,
   input  wire logic [15:0]           o_mem_data,
   input  wire logic                  o_mem_select,
   input  wire logic [7:0]            o_gpio_out,
   input  wire logic [7:0]            o_pld_pin_out,
   input  wire logic                  o_data_port_oe,
   input  wire logic                  o_periph_oe,
   input  wire logic                  o_power_down_signal,
   input  wire apdu_pkg::apdu_count_t o_idle_count
);
   import apdu_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // Power-down held long enough for blocking to have settled
   sequence s_down;
      o_power_down_signal [*3];
   endsequence
   // A wake source seen while powered down
   sequence s_strobe_wake;
      o_power_down_signal && $changed(i_address_strobe);
   endsequence
   chk_mem_deselect: assert property (s_down |-> !o_mem_select)
      else $error("memories selected in power-down");
   chk_bus_frozen: assert property (s_down |->
      $stable(o_mem_addr_lo) && $stable(o_mem_data))
      else $error("bus reached memories in power-down");
   chk_oe_blocked: assert property (s_down |->
      !o_data_port_oe && !o_periph_oe)
      else $error("data or peripheral port driven in power-down");
   chk_pins_pass: assert property ($past(i_rst_b) |->
      o_gpio_out == $past(i_gpio_out)
      && o_pld_pin_out == $past(i_pld_out))
      else $error("gpio or pld pin level not kept");
   chk_wake_strobe: assert property (s_strobe_wake |->
      ##[1:2] !o_power_down_signal)
      else $error("strobe activity did not wake");
   chk_wake_cs: assert property (o_power_down_signal
      && $fell(i_chip_select_b) |-> ##[1:2] !o_power_down_signal)
      else $error("chip select low did not wake");
   chk_wake_reset: assert property (o_power_down_signal
      && $rose(i_warm_reset_b) |-> ##[1:2] !o_power_down_signal)
      else $error("reset release did not wake");
   chk_count_clear: assert property ($changed(i_address_strobe) |->
      ##[1:3] o_idle_count == `APDU_CNT_ZERO)
      else $error("strobe pulse did not clear idle count");
   chk_pd_at_limit: assert property ($rose(o_power_down_signal) |->
      o_idle_count == `APDU_IDLE_LIMIT
      || $past(o_idle_count) == `APDU_IDLE_LIMIT)
      else $error("power-down before fifteen idle periods");
   chk_cs_idles_mem: assert property ($past(i_chip_select_b) |->
      !o_mem_select)
      else $error("memories selected with chip select high");
endmodule

bind apdu_top apdu_assertions u_chk
(
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_address_strobe(i_address_strobe),
   .i_chip_select_b(i_chip_select_b), .i_warm_reset_b(i_warm_reset_b),
   .i_gpio_out(i_gpio_out), .i_pld_out(i_pld_out),
   .o_mem_addr_lo(o_mem_addr_lo), .o_mem_data(o_mem_data),
   .o_mem_select(o_mem_select), .o_gpio_out(o_gpio_out),
   .o_pld_pin_out(o_pld_pin_out), .o_data_port_oe(o_data_port_oe),
   .o_periph_oe(o_periph_oe), .o_power_down_signal(o_power_down_signal),
   .o_idle_count(o_idle_count)
);

// >>> dv/apdu_mcu_model.sv
/*
 * Microcontroller and board clock model: address strobe, a bus that
 * changes every cycle, and a PLD clock that stands low between bursts.
 * Assumes its controls change just after the rising edge of i_clk.
 */
`timescale 1ns/1ps

module apdu_mcu_model
(
   input  wire logic        i_clk,
   input  wire logic        i_bus_run,
   input  wire logic        i_clk_run,
   output      logic        o_address_strobe,
   output      logic [7:0]  o_mcu_addr_lo,
   output      logic [15:0] o_mcu_data,
   output      logic        o_pld_clock_input
);
   logic        strobe  = 1'b0;   // Strobe level, rests when bus idles
   logic [1:0]  clk_div = 2'h0;   // Four cycles a PLD clock period
   logic [15:0] noise   = 16'h0;  // Bus noise, never settles
   // Strobe toggles each cycle while the MCU is active
   always @(posedge i_clk)
   begin
      if (i_bus_run)
      begin
         strobe <= ~strobe;
      end
      noise <= noise + 16'h1357;
   end
   // PLD clock runs only in bursts, low otherwise
   always @(posedge i_clk)
   begin
      clk_div <= i_clk_run ? clk_div + 2'h1 : 2'h0;
   end
   assign o_address_strobe  = strobe;
   assign o_mcu_addr_lo     = noise[7:0];
   assign o_mcu_data        = noise;
   assign o_pld_clock_input = clk_div[1];
endmodule

// >>> dv/apdu_top_tb_top.sv
/*
 * Bench of the automatic power-down unit: registers, input gating,
 * idle counting, power-down entry and every wake-up source.
 * Assumes the design files and the MCU model are compiled first.
 */
`timescale 1ns/1ps

module apdu_top_tb_top;
   import apdu_pkg::*;
   logic        i_clk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0;
   logic        i_reg_sel = 1'b0, i_strobe_pd_polarity = 1'b0;
   logic        i_chip_select_b = 1'b0, i_warm_reset_b = 1'b1;
   logic        i_high_write_or_byte_enable = 1'b1;
   logic        i_data_port_oe = 1'b1, i_periph_oe = 1'b1;
   logic        bus_run = 1'b0, clk_run = 1'b0, seen_clk = 1'b0;
   logic [2:0]  i_mcu_control_inputs = 3'h7;
   logic [7:0]  i_gpio_out = 8'ha5, i_pld_out = 8'h3c;
   logic [7:0]  i_periph_out = 8'h5a, snap;
   logic [15:0] i_data_port_out = 16'hc3c3, i_mcu_data;
   apdu_byte_t  i_reg_wdata = 8'h00, o_reg_rdata;
   apdu_count_t o_idle_count;
   logic        i_address_strobe, i_pld_clock_input, o_mem_select;
   logic [7:0]  i_mcu_addr_lo, o_mem_addr_lo, o_pld_addr_lo;
   logic [7:0]  o_gpio_out, o_pld_pin_out, o_periph_out, o_latched_addr_out;
   logic [2:0]  o_pld_control_inputs;
   logic        o_pld_address_strobe, o_pld_high_write, o_pld_clock;
   logic        o_pld_low_power, o_data_port_oe, o_periph_oe;
   logic        o_power_down_signal;
   logic [15:0] o_data_port_out;
   int          fails = 0, total_checks = 0;

   apdu_mcu_model mcu
   (
      .i_clk, .i_bus_run(bus_run), .i_clk_run(clk_run),
      .o_address_strobe(i_address_strobe), .o_mcu_addr_lo(i_mcu_addr_lo),
      .o_mcu_data(i_mcu_data), .o_pld_clock_input(i_pld_clock_input)
   );
   apdu_top dut
   (
      .i_clk, .i_rst_b, .i_reg_wr, .i_reg_sel, .i_reg_wdata, .o_reg_rdata,
      .i_address_strobe, .i_strobe_pd_polarity, .i_mcu_addr_lo,
      .i_mcu_data, .i_mcu_control_inputs, .i_high_write_or_byte_enable,
      .i_pld_clock_input, .i_chip_select_b, .i_warm_reset_b,
      .i_gpio_out, .i_pld_out, .i_data_port_out, .i_data_port_oe,
      .i_periph_out, .i_periph_oe, .o_mem_addr_lo, .o_mem_data(),
      .o_mem_select, .o_pld_addr_lo, .o_pld_control_inputs,
      .o_pld_address_strobe, .o_pld_high_write, .o_pld_clock,
      .o_pld_low_power, .o_gpio_out, .o_pld_pin_out, .o_data_port_out,
      .o_data_port_oe, .o_periph_out, .o_periph_oe,
      .o_latched_addr_out, .o_power_down_signal, .o_idle_count
   );

   // 10 MHz clock
   always #50 i_clk = ~i_clk;

   // Cycles pass; remembers whether the PLD clock ever reached the array
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge i_clk);
         #10;
         seen_clk = seen_clk | o_pld_clock;
      end
   endtask
   // One comparison
   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask
   // Register write, then two quiet cycles so strobes never merge
   task automatic wr(input logic sel, input apdu_byte_t data);
      i_reg_wr = 1'b1;
      i_reg_sel = sel;
      i_reg_wdata = data;
      tick(1);
      i_reg_wr = 1'b0;
      tick(2);
   endtask
   task automatic rd(input logic sel, input apdu_byte_t exp);
      i_reg_sel = sel;
      tick(2);
      chk("reg_rdata", {8'h00, exp}, {8'h00, o_reg_rdata});
   endtask
   // Strobe idle for n PLD clock periods, then the clock stands
   task automatic idle(input int n);
      clk_run = 1'b1;
      tick(4 * n);
      clk_run = 1'b0;
      tick(8);
   endtask
   // Strobe activity for n cycles
   task automatic pulse(input int n);
      bus_run = 1'b1;
      tick(n);
      bus_run = 1'b0;
      tick(3);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial
   begin
      tick(3);
      i_rst_b = 1'b1;
      rd(1'b0, 8'h00);
      rd(1'b1, 8'h00);
      pulse(1);
      wr(1'b1, 8'h7d);
      chk("pld_addr", 16'h0, o_pld_addr_lo);
      chk("pld_ctrl", 16'h0, o_pld_control_inputs);
      chk("pld_strobe", 16'h0, o_pld_address_strobe);
      chk("pld_high_wr", 16'h0, o_pld_high_write);
      wr(1'b1, 8'h00);
      chk("pld_ctrl", 16'h7, o_pld_control_inputs);
      chk("pld_strobe", 16'h1, o_pld_address_strobe);
      chk("pld_high_wr", 16'h1, o_pld_high_write);
      snap = i_mcu_addr_lo;
      tick(1);
      chk("pld_addr", snap, o_pld_addr_lo);
      chk("mem_addr", snap, o_mem_addr_lo);
      chk("latched_addr", snap, o_latched_addr_out);
      wr(1'b0, 8'h22);
      idle(15);
      chk("pd", 16'h0, o_power_down_signal);
      chk("idle_count", 16'h0, o_idle_count);
      chk("low_power", 16'h0, o_pld_low_power);
      i_strobe_pd_polarity = 1'b1;
      wr(1'b0, 8'h20);
      idle(15);
      chk("pd", 16'h0, o_power_down_signal);
      chk("idle_count", 16'h0, o_idle_count);
      wr(1'b0, 8'h32);
      seen_clk = 1'b0;
      idle(14);
      chk("idle_count", 16'he, o_idle_count);
      chk("pd", 16'h0, o_power_down_signal);
      chk("pld_clock", 16'h0, seen_clk);
      idle(1);
      chk("pd", 16'h1, o_power_down_signal);
      chk("mem_select", 16'h0, o_mem_select);
      chk("data_oe", 16'h0, o_data_port_oe);
      chk("periph_oe", 16'h0, o_periph_oe);
      chk("gpio", i_gpio_out, o_gpio_out);
      chk("pld_pin", i_pld_out, o_pld_pin_out);
      chk("data_port", i_data_port_out, o_data_port_out);
      chk("periph", i_periph_out, o_periph_out);
      snap = o_mem_addr_lo;
      tick(3);
      chk("mem_addr", snap, o_mem_addr_lo);
      chk("pld_addr", snap, o_pld_addr_lo);
      pulse(2);
      chk("pd", 16'h0, o_power_down_signal);
      chk("idle_count", 16'h0, o_idle_count);
      chk("mem_select", 16'h1, o_mem_select);
      wr(1'b0, 8'h22);
      seen_clk = 1'b0;
      idle(15);
      chk("pd", 16'h1, o_power_down_signal);
      chk("pld_clock", 16'h1, seen_clk);
      i_chip_select_b = 1'b1;
      tick(2);
      i_chip_select_b = 1'b0;
      tick(3);
      chk("pd", 16'h0, o_power_down_signal);
      i_chip_select_b = 1'b1;
      tick(2);
      chk("mem_select", 16'h0, o_mem_select);
      chk("data_oe", 16'h1, o_data_port_oe);
      i_chip_select_b = 1'b0;
      tick(2);
      idle(15);
      i_warm_reset_b = 1'b0;
      tick(2);
      i_warm_reset_b = 1'b1;
      tick(3);
      chk("pd", 16'h0, o_power_down_signal);
      rd(1'b0, 8'h22);
      wr(1'b0, 8'h2a);
      chk("low_power", 16'h1, o_pld_low_power);
      finish_test;
   end

   // Watchdog against a hang
   initial
   begin
      repeat (4000) @(posedge i_clk);
      fails++;
      finish_test;
   end
endmodule
